//--- pkg/lsat_pkg.sv
// Register map, field positions, reset values and state record of the block
`default_nettype none
package lsat_pkg;
    localparam logic [7:0] ADDR_STATUS_ONE = 8'h41;
    localparam logic [7:0] ADDR_STATUS_TWO = 8'h42;
    localparam logic [7:0] ADDR_MASK_ONE = 8'h74;
    localparam logic [7:0] ADDR_MASK_TWO = 8'h75;
    localparam logic [7:0] ADDR_CONFIG_THREE = 8'h78;
    localparam logic [7:0] ADDR_TIMER = 8'h79;
    localparam logic [7:0] ADDR_TIMER_LIMIT = 8'h7A;
    localparam logic [7:0] ADDR_CONFIG_FOUR = 8'h7D;

    localparam int CFG3_ALERT_BIT = 0;
    localparam int CFG3_OVERHEAT_BIT = 1;
    localparam int CFG3_BOOST_BIT = 2;
    localparam int S2_COOLER4_BIT = 5;
    localparam int S2_CODE_BIT = 0;
    localparam int M1_SECOND_BIT = 7;

    // Multi-function pin select, field value is {bit1, bit0}
    localparam logic [1:0] MF_SPEED = 2'h0;
    localparam logic [1:0] MF_ALERT = 2'h1;
    localparam logic [1:0] MF_OVERHEAT = 2'h2;
    localparam logic [1:0] MF_GPIO = 2'h3;

    localparam logic [7:0] RESET_MASK = 8'h00;
    localparam logic [7:0] RESET_CONFIG = 8'h00;
    localparam logic [7:0] RESET_LIMIT = 8'h00;
    localparam logic [7:0] RESET_TIMER = 8'h00;
    localparam logic [7:0] TIMER_FULL = 8'hFF;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    localparam int CLK_HZ = 25000000;
    localparam real TIMER_STEP_MS = 22.76;
    localparam int TIMER_STEP_CYCLES =
        int'($floor(TIMER_STEP_MS * CLK_HZ / 1000.0 + 0.5));
    localparam int PRESCALE_WIDTH = 20;

    typedef struct packed {
        logic [6:0] status_one;
        logic [7:0] status_two;
        logic [7:0] mask_one;
        logic [7:0] mask_two;
        logic [7:0] config_three;
        logic [7:0] config_four;
        logic [7:0] timer_limit;
        logic [7:0] timer;
        logic half_step_seen;
        logic [PRESCALE_WIDTH-1:0] prescale;
        logic [1:0] pin_sync1;
        logic [1:0] pin_sync2;
        logic [5:0] code_sync1;
        logic [5:0] code_sync2;
        logic [5:0] code_prev;
        logic code_primed;
        logic [1:0] code_warm;
        logic [7:0] read_data;
        logic alert_shared_n;
        logic mf_pin_out;
        logic mf_pin_oe_n;
        logic fan_full_duty;
    } lsat_state_type;
endpackage : lsat_pkg
`default_nettype wire

//--- verilog/lsat_alert_timer.sv
// Sticky limit status, alert masking, pin select and overheat timer
// How it works
// RULE1: A channel out of limits sets its status flag to one.
// RULE2: Flags stay set; a status read clears them only once cause is gone.
// RULE3: Bit 7 of status one reads one while any status two flag is set.
// RULE4: Status one bits 6..0: remote2, local, remote1, 5V, supply, core, 2.5V.
// RULE5: Status two: diodes 7,6, fans 4..2, overheat limit 1.
// RULE6: Status two bit 5 is fourth fan, or timer over limit in overheat mode.
// RULE7: Status two bit 0 is 12V, or core code change when that mode is on.
// RULE8: Alert stays low while unmasked reading is bad and until status read.
// RULE9: Mask bits block only the alert; flags still set.
// RULE10: Mask one: bit 7 all of status two, 6..2 matching, 0 core rail.
// RULE11: Mask two masks diodes, fans, overheat; bit 5 also timer event.
// RULE12: Alert off after reset; config three bit 0 routes it to shared pin.
// RULE13: Config four bits 1..0 pick speed, overheat, alert or GPIO pin use; here speed and GPIO leave the pin idle.
// RULE14: Config three bit 1 enables overheat inputs on both pins.
// RULE15: Boost bit plus overheat forces full duty only if fan runs.
// RULE16: Timer counts while overheat asserted, pauses otherwise, accumulates.
// RULE17: Timer clears on read and saturates at full scale.
// RULE18: Bit 0 sets on first assertion; later one step is 22.76 ms.
// RULE19: Read during assertion restarts at one; zero limit sets timer flag.
// RULE20: Host reads status two after timer read to clear timer flag.
// RULE21: Host reads, masks, handles, polls, then unmasks cleared sources.
// RULE22: Timer above limit sets the timer flag and alerts unless masked.
// RULE23: Alert is the OR of all unmasked flags, released when none remain.
`default_nettype none
module lsat_alert_timer #(
    parameter int unsigned TIMER_STEP_CYCLES = lsat_pkg::TIMER_STEP_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [6:0] limit_one,
    input wire logic [7:0] limit_two,
    input wire logic code_change_mode,
    input wire logic [5:0] core_voltage_code,
    input wire logic overheat_signal_n,
    input wire logic mf_pin_in,
    input wire logic fan_running,
    output logic alert_shared_n,
    output logic mf_pin_out,
    output logic mf_pin_oe_n,
    output logic fan_full_duty
);
    lsat_pkg::lsat_state_type state;
    lsat_pkg::lsat_state_type next_state;

    logic rd_status_one;
    logic rd_status_two;
    logic rd_timer;
    logic overheat_enabled;
    logic overheat_active;
    logic step_done;
    logic timer_over;
    logic code_changed;
    logic [7:0] cause_two;
    logic [6:0] unmasked_one;
    logic [7:0] unmasked_two;
    logic alert_req;
    logic summary;

    localparam logic [lsat_pkg::PRESCALE_WIDTH-1:0] PRESCALE_LAST =
        lsat_pkg::PRESCALE_WIDTH'(TIMER_STEP_CYCLES - 1);

    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] target);
        hit = (addr == target);
    endfunction : hit

    // Set wins over the read clear; a read clears only flags whose cause ended
    function automatic logic [7:0] sticky(input logic [7:0] flags,
                                          input logic [7:0] cause,
                                          input logic rd);
        sticky = (flags & ~(rd ? ~cause : 8'h00)) | cause;
    endfunction : sticky

    always_comb begin
        rd_status_one = reg_rd && hit(reg_addr, lsat_pkg::ADDR_STATUS_ONE);
        rd_status_two = reg_rd && hit(reg_addr, lsat_pkg::ADDR_STATUS_TWO);
        rd_timer = reg_rd && hit(reg_addr, lsat_pkg::ADDR_TIMER);
        overheat_enabled = state.config_three[lsat_pkg::CFG3_OVERHEAT_BIT];
        // Dedicated pin, or multi-function pin when selected for overheat
        overheat_active = overheat_enabled && (!state.pin_sync2[0] ||
            (state.config_four[1:0] == lsat_pkg::MF_OVERHEAT &&
             !state.pin_sync2[1])); // RULE14 RULE13
        step_done = overheat_active &&
            state.prescale == PRESCALE_LAST;
        timer_over = state.timer > state.timer_limit; // RULE22
        code_changed = state.code_primed &&
            state.code_sync2 != state.code_prev;
        cause_two = limit_two; // RULE5
        if (overheat_enabled) begin
            cause_two[lsat_pkg::S2_COOLER4_BIT] = timer_over; // RULE6
        end
        if (code_change_mode) begin
            cause_two[lsat_pkg::S2_CODE_BIT] = code_changed; // RULE7
        end
        summary = |state.status_two; // RULE3
        // Mask one bit 1 is unused; its bit 0 covers the core rail flag
        unmasked_one = state.status_one &
            ~{state.mask_one[6:2], state.mask_one[0], 1'b0}; // RULE10 RULE9
        unmasked_two = state.status_two & ~state.mask_two &
            {8{~state.mask_one[lsat_pkg::M1_SECOND_BIT]}}; // RULE11 RULE10
        alert_req = (|unmasked_one) || (|unmasked_two); // RULE23 RULE8
    end

    always_comb begin
        next_state = state;
        next_state.pin_sync1 = {mf_pin_in, overheat_signal_n};
        next_state.pin_sync2 = state.pin_sync1;
        next_state.code_sync1 = core_voltage_code;
        next_state.code_sync2 = state.code_sync1;
        next_state.code_prev = state.code_sync2;
        // Detection waits until the code pipeline holds real pin values
        next_state.code_warm = {state.code_warm[0], 1'b1};
        next_state.code_primed = state.code_warm[1];

        // Sticky status flags
        next_state.status_one = 7'(sticky({1'b0, state.status_one},
            {1'b0, limit_one}, rd_status_one)); // RULE1 RULE2 RULE4
        next_state.status_two = sticky(state.status_two, cause_two,
            rd_status_two); // RULE1 RULE2 RULE22

        // Accumulating overheat timer
        if (rd_timer) begin
            next_state.timer = overheat_active ? 8'h01 :
                lsat_pkg::RESET_TIMER; // RULE17 RULE19
            next_state.half_step_seen = 1'b0;
            next_state.prescale = '0;
        end else if (overheat_active) begin // RULE16
            if (state.timer == lsat_pkg::RESET_TIMER) begin
                next_state.timer = 8'h01; // RULE18
            end
            if (step_done) begin
                next_state.prescale = '0;
                if (!state.half_step_seen) begin
                    next_state.half_step_seen = 1'b1; // RULE18
                end else if (state.timer != lsat_pkg::TIMER_FULL) begin
                    next_state.timer = state.timer + 8'h01; // RULE17
                end
            end else begin
                next_state.prescale = state.prescale +
                    lsat_pkg::PRESCALE_WIDTH'(1);
            end
        end

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                lsat_pkg::ADDR_MASK_ONE: next_state.mask_one = reg_wdata;
                lsat_pkg::ADDR_MASK_TWO: next_state.mask_two = reg_wdata;
                lsat_pkg::ADDR_CONFIG_THREE: begin
                    next_state.config_three = reg_wdata;
                end
                lsat_pkg::ADDR_CONFIG_FOUR: begin
                    next_state.config_four = reg_wdata;
                end
                lsat_pkg::ADDR_TIMER_LIMIT: begin
                    next_state.timer_limit = reg_wdata;
                end
                default: begin
                end
            endcase
        end

        // Register reads, answered on the next edge
        if (reg_rd) begin
            unique case (reg_addr)
                lsat_pkg::ADDR_STATUS_ONE: begin
                    next_state.read_data = {summary, state.status_one};
                end
                lsat_pkg::ADDR_STATUS_TWO: begin
                    next_state.read_data = state.status_two;
                end
                lsat_pkg::ADDR_MASK_ONE: next_state.read_data = state.mask_one;
                lsat_pkg::ADDR_MASK_TWO: next_state.read_data = state.mask_two;
                lsat_pkg::ADDR_CONFIG_THREE: begin
                    next_state.read_data = state.config_three;
                end
                lsat_pkg::ADDR_TIMER: next_state.read_data = state.timer;
                lsat_pkg::ADDR_TIMER_LIMIT: begin
                    next_state.read_data = state.timer_limit;
                end
                lsat_pkg::ADDR_CONFIG_FOUR: begin
                    next_state.read_data = state.config_four;
                end
                default: next_state.read_data = lsat_pkg::READ_UNMAPPED;
            endcase
        end

        // Pin drivers
        next_state.alert_shared_n = !(alert_req &&
            state.config_three[lsat_pkg::CFG3_ALERT_BIT]); // RULE12 RULE8
        next_state.mf_pin_out = 1'b0;
        next_state.mf_pin_oe_n = !(alert_req &&
            state.config_four[1:0] == lsat_pkg::MF_ALERT); // RULE13
        next_state.fan_full_duty =
            state.config_three[lsat_pkg::CFG3_BOOST_BIT] &&
            overheat_active && fan_running; // RULE15
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
            state.mask_one <= lsat_pkg::RESET_MASK;
            state.mask_two <= lsat_pkg::RESET_MASK;
            state.config_three <= lsat_pkg::RESET_CONFIG;
            state.config_four <= lsat_pkg::RESET_CONFIG;
            state.timer_limit <= lsat_pkg::RESET_LIMIT;
            state.timer <= lsat_pkg::RESET_TIMER;
            state.read_data <= lsat_pkg::READ_UNMAPPED;
            state.pin_sync1 <= 2'h3;
            state.pin_sync2 <= 2'h3;
            state.alert_shared_n <= 1'b1;
            state.mf_pin_oe_n <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.read_data;
    assign alert_shared_n = state.alert_shared_n;
    assign mf_pin_out = state.mf_pin_out;
    assign mf_pin_oe_n = state.mf_pin_oe_n;
    assign fan_full_duty = state.fan_full_duty;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_flag_set_cause: assert property ( // RULE1
        |limit_one |=> (state.status_one & $past(limit_one)) ==
            $past(limit_one))
        else $error("status one flag not set by its cause");
    a_flag_sticky_hold: assert property ( // RULE2
        !rd_status_one |=> (state.status_one & $past(state.status_one)) ==
            $past(state.status_one))
        else $error("status one flag dropped without a read");
    a_summary_bit_read: assert property ( // RULE3
        rd_status_one |=> reg_rdata[7] == $past(summary))
        else $error("summary bit does not follow status two");
    a_timer_flag_set: assert property ( // RULE22
        overheat_enabled && timer_over |=>
            state.status_two[lsat_pkg::S2_COOLER4_BIT])
        else $error("timer over limit did not set its flag");
    a_code_change_flag: assert property ( // RULE7
        code_change_mode && code_changed |=>
            state.status_two[lsat_pkg::S2_CODE_BIT])
        else $error("code change not flagged");
    a_alert_follows_flags: assert property ( // RULE8
        alert_req && state.config_three[lsat_pkg::CFG3_ALERT_BIT] |=>
            !alert_shared_n)
        else $error("alert not driven for unmasked flag");
    a_mask_blocks_alert: assert property ( // RULE9
        state.mask_one == 8'hFF && state.mask_two == 8'hFF &&
        !state.status_one[0] |=> alert_shared_n && mf_pin_oe_n)
        else $error("masked source drove alert");
    a_alert_route_off: assert property ( // RULE12
        !state.config_three[lsat_pkg::CFG3_ALERT_BIT] |=> alert_shared_n)
        else $error("alert driven on shared pin while not routed");
    a_mf_alert_pin: assert property ( // RULE13
        alert_req && state.config_four[1:0] == lsat_pkg::MF_ALERT |=>
            !mf_pin_oe_n)
        else $error("multi-function pin not driving alert");
    a_overheat_gate: assert property ( // RULE14
        !overheat_enabled |-> !overheat_active)
        else $error("overheat active while disabled");
    a_boost_full_duty: assert property ( // RULE15
        state.config_three[lsat_pkg::CFG3_BOOST_BIT] && overheat_active &&
        fan_running |=> fan_full_duty)
        else $error("boost did not force full duty");
    a_timer_pause_idle: assert property ( // RULE16
        !overheat_active && !rd_timer |=> $stable(state.timer))
        else $error("timer moved while overheat idle");
    a_timer_read_clear: assert property ( // RULE17
        rd_timer && !overheat_active |=> state.timer == 8'h00)
        else $error("timer not cleared by read");
    a_timer_saturate_hold: assert property ( // RULE17
        state.timer == 8'hFF && !rd_timer |=> state.timer == 8'hFF)
        else $error("timer left full scale without read");
    a_timer_first_assert: assert property ( // RULE18
        overheat_active && state.timer == 8'h00 && !rd_timer |=>
            state.timer == 8'h01)
        else $error("timer bit 0 not set on first assertion");
    a_timer_read_active: assert property ( // RULE19
        rd_timer && overheat_active |=> state.timer == 8'h01)
        else $error("timer read during assertion not restarted at one");

    a_flag_two_sticky: assert property ( // RULE2
        !rd_status_two |=> (state.status_two & $past(state.status_two)) ==
            $past(state.status_two))
        else $error("status two flag dropped without a read");
    a_read_clears_gone: assert property ( // RULE2
        rd_status_one |=> (state.status_one & ~$past(limit_one)) == 7'h00)
        else $error("status one flag kept after its cause ended");
    a_flag_two_set: assert property ( // RULE5
        |cause_two |=> (state.status_two & $past(cause_two)) ==
            $past(cause_two))
        else $error("status two flag not set by its cause");
    a_flag_masked_set: assert property ( // RULE9
        |limit_one && state.mask_one == 8'hFF |=>
            (state.status_one & $past(limit_one)) == $past(limit_one))
        else $error("masked source did not set its flag");
    a_alert_release_idle: assert property ( // RULE23
        !alert_req |=> alert_shared_n && mf_pin_oe_n)
        else $error("alert held with no unmasked flag");
    a_status_one_read: assert property ( // RULE4
        rd_status_one |=> reg_rdata[6:0] == $past(state.status_one))
        else $error("status one read data wrong");
    a_status_two_read: assert property ( // RULE5
        rd_status_two |=> reg_rdata == $past(state.status_two))
        else $error("status two read data wrong");
    a_timer_half_step: assert property ( // RULE18
        step_done && !state.half_step_seen && !rd_timer &&
        state.timer != 8'h00 |=> $stable(state.timer))
        else $error("timer stepped before the half step");
    a_timer_step_up: assert property ( // RULE16
        step_done && state.half_step_seen && !rd_timer &&
        state.timer != 8'hFF |=> state.timer == $past(state.timer) + 8'h01)
        else $error("timer did not advance on a step");
    a_gpio_pin_idle: assert property ( // RULE13
        state.config_four[1:0] != lsat_pkg::MF_ALERT |=> mf_pin_oe_n)
        else $error("multi-function pin driven while not alert");
    a_boost_needs_fan: assert property ( // RULE15
        !fan_running || !state.config_three[lsat_pkg::CFG3_BOOST_BIT] |=>
            !fan_full_duty)
        else $error("full duty forced without boost and running fan");
    a_fan_idle_cool: assert property ( // RULE15
        !overheat_active |=> !fan_full_duty)
        else $error("full duty forced with no overheat");
    a_mf_overheat_src: assert property ( // RULE14
        overheat_enabled && !state.pin_sync2[1] &&
        state.config_four[1:0] == lsat_pkg::MF_OVERHEAT |-> overheat_active)
        else $error("multi-function overheat input ignored");
    a_mask_two_alert: assert property ( // RULE11
        state.mask_two[5] && state.status_two == 8'h20 &&
        state.status_one == 7'h00 |=> alert_shared_n && mf_pin_oe_n)
        else $error("masked timer event drove alert");

    c_alert_low: cover property (!alert_shared_n);
    c_read_while_hot: cover property (rd_timer && overheat_active);
    c_timer_two: cover property (state.timer == 8'h02);
    c_mf_alert: cover property (!mf_pin_oe_n);
    c_timer_full: cover property (state.timer == 8'hFF);
endmodule : lsat_alert_timer
`default_nettype wire

//--- tb/lsat_pin_model.sv
// Far-side pin model: overheat sources and core code pins on a slow clock
`default_nettype none
module lsat_pin_model (
    input wire logic hot_req,
    input wire logic hot_sel,
    input wire logic [5:0] code_req,
    output logic overheat_signal_n,
    output logic mf_drive_n,
    output logic [5:0] core_voltage_code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic link_clk = 1'b0;
    initial begin
        overheat_signal_n = 1'b1;
        mf_drive_n = 1'b1;
        core_voltage_code = 6'h00;
    end
    always #160 link_clk = ~link_clk;
    // Pins change only on the slow edge, unrelated to the block clock
    always @(posedge link_clk) begin
        overheat_signal_n <= ~(hot_req & ~hot_sel);
        mf_drive_n <= ~(hot_req & hot_sel);
        core_voltage_code <= code_req;
    end
endmodule : lsat_pin_model
`default_nettype wire

//--- tb/lsat_alert_timer_tb.sv
// Self-checking bench for the limit status, alert and timer block
`default_nettype none
module lsat_alert_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STEP = 8;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [6:0] limit_one = 7'h00;
    logic [7:0] limit_two = 8'h00;
    logic code_change_mode = 1'b0;
    logic fan_running = 1'b0;
    logic [5:0] core_voltage_code;
    logic overheat_signal_n, mf_pin_in, mf_drive_n;
    logic alert_shared_n, mf_pin_out, mf_pin_oe_n, fan_full_duty;
    logic hot_req = 1'b0;
    logic hot_sel = 1'b0;
    logic [5:0] code_req = 6'h00;
    logic [7:0] m1, m2, s2, ea;
    logic [6:0] s1;
    int act = 0;
    int a0;
    int n_mismatch = 0;
    int total_checks = 0;
    always #20 clk = ~clk;
    // Open-drain pin: pulled up, low when either party pulls
    assign mf_pin_in = mf_pin_oe_n ? mf_drive_n : mf_pin_out;
    always @(posedge clk) begin
        if (!(hot_sel ? mf_pin_in : overheat_signal_n)) begin
            act <= act + 1;
        end
    end
    lsat_pin_model u_lsat_pin_model (.hot_req(hot_req), .hot_sel(hot_sel),
        .code_req(code_req), .overheat_signal_n(overheat_signal_n),
        .mf_drive_n(mf_drive_n), .core_voltage_code(core_voltage_code));
    lsat_alert_timer #(.TIMER_STEP_CYCLES(STEP)) u_lsat_alert_timer (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .limit_one(limit_one), .limit_two(limit_two),
        .code_change_mode(code_change_mode),
        .core_voltage_code(core_voltage_code),
        .overheat_signal_n(overheat_signal_n), .mf_pin_in(mf_pin_in),
        .fan_running(fan_running), .alert_shared_n(alert_shared_n),
        .mf_pin_out(mf_pin_out), .mf_pin_oe_n(mf_pin_oe_n),
        .fan_full_duty(fan_full_duty));
    function automatic logic exp_alert(input logic [6:0] f1,
        input logic [7:0] f2, input logic [7:0] k1, input logic [7:0] k2);
        return f1[0] | (f1[1] & ~k1[0]) | (|(f1[6:2] & ~k1[6:2]))
            | ((|(f2 & ~k2)) & ~k1[7]);
    endfunction : exp_alert
    function automatic logic [7:0] exp_t(input int a);
        if (a == 0) return 8'h00;
        if (a < 2 * STEP + 1) return 8'h01;
        if (2 + (a - 2 * STEP - 1) / STEP > 255) return 8'hFF;
        return 8'(2 + (a - 2 * STEP - 1) / STEP);
    endfunction : exp_t
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
        input logic near = 1'b0);
        total_checks++;
        if (!(got === exp || (near && (got === exp + 8'h01
            || got === exp - 8'h01)))) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] e,
        input logic near = 1'b0);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk(reg_rdata, e, near);
    endtask : rdc
    task automatic hot(input logic sel, input int n);
        @(negedge clk);
        hot_sel = sel;
        hot_req = 1'b1;
        repeat (n) @(negedge clk);
        hot_req = 1'b0;
        repeat (20) @(negedge clk);
    endtask : hot
    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    initial begin
        #1000000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        void'($urandom(28055));
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        chk({7'h00, alert_shared_n}, 8'h01);
        chk({7'h00, mf_pin_oe_n}, 8'h01);
        rdc(lsat_pkg::ADDR_MASK_ONE, lsat_pkg::RESET_MASK);
        rdc(lsat_pkg::ADDR_MASK_TWO, lsat_pkg::RESET_MASK);
        rdc(lsat_pkg::ADDR_CONFIG_THREE, lsat_pkg::RESET_CONFIG);
        rdc(lsat_pkg::ADDR_CONFIG_FOUR, lsat_pkg::RESET_CONFIG);
        rdc(lsat_pkg::ADDR_TIMER_LIMIT, lsat_pkg::RESET_LIMIT);
        wr(lsat_pkg::ADDR_TIMER, 8'h5A);
        rdc(lsat_pkg::ADDR_TIMER, lsat_pkg::RESET_TIMER);
        wr(8'h10, 8'hA5);
        rdc(8'h10, lsat_pkg::READ_UNMAPPED);
        // Flag held while its cause stays high across reads
        limit_one = 7'h20;
        repeat (3) @(negedge clk);
        rdc(lsat_pkg::ADDR_STATUS_ONE, 8'h20);
        rdc(lsat_pkg::ADDR_STATUS_ONE, 8'h20);
        limit_one = 7'h00;
        rdc(lsat_pkg::ADDR_STATUS_ONE, 8'h20);
        rdc(lsat_pkg::ADDR_STATUS_ONE, 8'h00);
        wr(lsat_pkg::ADDR_CONFIG_THREE, 8'h01);
        wr(lsat_pkg::ADDR_CONFIG_FOUR, {6'h00, lsat_pkg::MF_ALERT});
        for (int i = 0; i < 10; i++) begin
            m1 = 8'($urandom);
            m2 = 8'($urandom);
            s1 = 7'($urandom);
            s2 = 8'($urandom);
            ea = {7'h00, ~exp_alert(s1, s2, m1, m2)};
            wr(lsat_pkg::ADDR_MASK_ONE, m1);
            wr(lsat_pkg::ADDR_MASK_TWO, m2);
            @(negedge clk);
            limit_one = s1;
            limit_two = s2;
            repeat (2) @(negedge clk);
            limit_one = 7'h00;
            limit_two = 8'h00;
            repeat (4) @(negedge clk);
            chk({7'h00, alert_shared_n}, ea);
            chk({7'h00, mf_pin_oe_n}, ea);
            rdc(lsat_pkg::ADDR_STATUS_ONE, {|s2, s1});
            rdc(lsat_pkg::ADDR_STATUS_TWO, s2);
            repeat (4) @(negedge clk);
            chk({7'h00, alert_shared_n}, 8'h01);
        end
        wr(lsat_pkg::ADDR_MASK_ONE, 8'h00);
        wr(lsat_pkg::ADDR_MASK_TWO, 8'h00);
        code_change_mode = 1'b1;
        code_req = 6'($urandom) | 6'h01;
        repeat (30) @(negedge clk);
        rdc(lsat_pkg::ADDR_STATUS_TWO, 8'h01);
        rdc(lsat_pkg::ADDR_STATUS_TWO, 8'h00);
        // Two bursts on the dedicated pin accumulate
        wr(lsat_pkg::ADDR_CONFIG_THREE, 8'h03);
        a0 = act;
        hot(1'b0, 100);
        hot(1'b0, 60);
        chk({7'h00, alert_shared_n}, 8'h00);
        rdc(lsat_pkg::ADDR_TIMER, exp_t(act - a0), 1'b1);
        rdc(lsat_pkg::ADDR_TIMER, 8'h00);
        rdc(lsat_pkg::ADDR_STATUS_TWO, 8'h20);
        rdc(lsat_pkg::ADDR_STATUS_TWO, 8'h00);
        @(negedge clk);
        hot_req = 1'b1;
        a0 = act;
        repeat (60) @(negedge clk);
        rdc(lsat_pkg::ADDR_TIMER, exp_t(act - a0), 1'b1);
        rdc(lsat_pkg::ADDR_TIMER, 8'h01);
        a0 = act;
        rdc(lsat_pkg::ADDR_STATUS_TWO, 8'h20);
        wr(lsat_pkg::ADDR_CONFIG_THREE, 8'h06);
        repeat (4) @(negedge clk);
        chk({7'h00, fan_full_duty}, 8'h00);
        fan_running = 1'b1;
        repeat (4) @(negedge clk);
        chk({7'h00, fan_full_duty}, 8'h01);
        hot_req = 1'b0;
        repeat (20) @(negedge clk);
        // Multi-function pin as overheat, timer event masked
        wr(lsat_pkg::ADDR_CONFIG_FOUR, {6'h00, lsat_pkg::MF_OVERHEAT});
        wr(lsat_pkg::ADDR_CONFIG_THREE, 8'h03);
        wr(lsat_pkg::ADDR_MASK_TWO, 8'h20);
        rdc(lsat_pkg::ADDR_TIMER, exp_t(act - a0 + 3), 1'b1);
        rdc(lsat_pkg::ADDR_STATUS_TWO, 8'h20);
        hot(1'b1, 2200);
        chk({7'h00, alert_shared_n}, 8'h01);
        rdc(lsat_pkg::ADDR_STATUS_TWO, 8'h20);
        rdc(lsat_pkg::ADDR_TIMER, lsat_pkg::TIMER_FULL);
        wr(lsat_pkg::ADDR_CONFIG_THREE, 8'h00);
        hot(1'b0, 100);
        hot(1'b1, 100);
        rdc(lsat_pkg::ADDR_TIMER, 8'h00);
        stop_test();
    end
endmodule : lsat_alert_timer_tb
`default_nettype wire
